/* common/hall_phase_pkg.sv */
// shared constants and types for the hall phase reference block
package hall_phase_pkg;
	// ----------------------------------------
	// register byte offsets
	// ----------------------------------------
	localparam logic [15:0] OFF_CONFIG   = 16'h0000;
	localparam logic [15:0] OFF_MODE     = 16'h0004;
	localparam logic [15:0] OFF_STORED   = 16'h0008;
	localparam logic [15:0] OFF_ANGLE    = 16'h000C;
	localparam logic [15:0] OFF_CYCLE    = 16'h0010;
	localparam logic [15:0] OFF_CONTROL  = 16'h0014;
	localparam logic [15:0] OFF_PHASE    = 16'h0018;
	localparam logic [15:0] OFF_STATUS   = 16'h001C;
	localparam logic [15:0] OFF_IRQ_STAT = 16'h0020;
	localparam logic [15:0] OFF_IRQ_MASK = 16'h0024;
	localparam logic [15:0] OFF_FLAGS    = 16'hC000;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CFG_HALL_BIT  = 23;
	localparam int CFG_DIR_BIT   = 22;
	localparam int CFG_OFF_LSB   = 16;
	localparam int FLAG_HALL_LSB = 20;
	localparam int ANGLE_SINE_BIT = 8;
	localparam int CTL_PHASE_BIT = 0;
	localparam int CTL_CORR_BIT  = 1;
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_FAIL      = 1;
	localparam int IRQ_CORR      = 2;
	localparam int IRQ_REFUSED   = 3;
	localparam int IRQ_W         = 4;
	// ----------------------------------------
	// reset values and mode codes
	// ----------------------------------------
	localparam logic [23:0] CONFIG_RESET = 24'h80C000;
	localparam logic [1:0]  MODE_RESET   = 2'h1;
	localparam logic [1:0]  MODE_AUTO    = 2'h1;
	localparam logic [23:0] CYCLE_RESET  = 24'h000800;
	localparam logic [7:0]  SINE_LIMIT   = 8'h80;
	// ----------------------------------------
	// angle units: 1/192 cycle holds both 1/64 offsets and zone midpoints
	// ----------------------------------------
	localparam logic [8:0] STEPS_PER_CYCLE = 9'h0C0;
	localparam logic [8:0] HALF_CYCLE      = 9'h060;
	localparam logic [1:0] OFFSET_SCALE    = 2'h3;
	// standard sense runs 3, 2, 6, 4, 5, 1; the 1 to 3 boundary is the cycle zero
	localparam logic [7:0] MID_STATE2 = 8'h30;
	localparam logic [7:0] MID_STATE6 = 8'h50;
	localparam logic [7:0] MID_STATE4 = 8'h70;
	localparam logic [7:0] MID_STATE5 = 8'h90;
	localparam logic [7:0] MID_STATE1 = 8'hB0;
	localparam logic [7:0] MID_STATE3 = 8'h10;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int SETTLE_NS     = 60;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_SETTLE, ST_LOAD} phase_state_e;
	typedef struct packed {
		logic t;
		logic u;
		logic v;
		logic w;
	} hall_pins_s;
	typedef struct packed {
		logic       reverse;
		logic [5:0] offset;
		logic       rotate;
	} map_cfg_s;
endpackage : hall_phase_pkg

/* rtl/hall_angle_map.sv */
// hall state to commutation angle, in 1/192 cycle
`timescale 1ns/10ps
module hall_angle_map (
	// sensor state {u, v, w} and setup
	input  wire logic [2:0]                uvw,
	input  wire hall_phase_pkg::map_cfg_s  cfg,
	// result
	output logic                           valid,
	output logic      [7:0]                angle
);
	logic [7:0] base;
	logic [7:0] dir;
	logic [9:0] sum;

	// zero sits on the v edge while u is low, between states 1 and 3
	always_comb begin
		valid = 1'b1;
		unique case (uvw)
			3'h2: base = hall_phase_pkg::MID_STATE2;
			3'h6: base = hall_phase_pkg::MID_STATE6;
			3'h4: base = hall_phase_pkg::MID_STATE4;
			3'h5: base = hall_phase_pkg::MID_STATE5;
			3'h1: base = hall_phase_pkg::MID_STATE1;
			3'h3: base = hall_phase_pkg::MID_STATE3;
			default: begin
				base  = 8'h00;
				valid = 1'b0;
			end
		endcase
	end

	// reversed sense mirrors the cycle; no midpoint is zero so no wrap case
	always_comb begin
		dir = cfg.reverse ? 8'(hall_phase_pkg::STEPS_PER_CYCLE - {1'b0, base}) : base;
		sum = {2'h0, dir} + 10'(cfg.offset * hall_phase_pkg::OFFSET_SCALE);
		if (cfg.rotate) begin
			sum = sum + {1'b0, hall_phase_pkg::HALF_CYCLE};
		end
		if (sum >= {1'b0, hall_phase_pkg::STEPS_PER_CYCLE}) begin
			sum = sum - {1'b0, hall_phase_pkg::STEPS_PER_CYCLE};
		end
		if (sum >= {1'b0, hall_phase_pkg::STEPS_PER_CYCLE}) begin
			sum = sum - {1'b0, hall_phase_pkg::STEPS_PER_CYCLE};
		end
		angle = sum[7:0];
	end
endmodule : hall_angle_map

/* rtl/hall_phase_reference.sv */
// hall phase reference: seeds the motor phase position from hall sensors
`timescale 1ns/10ps
// ------------------------------------------------------------------
// ------------------------------------------------------------------
module hall_phase_reference #(
	parameter logic [23:0] CONFIG_INIT = hall_phase_pkg::CONFIG_RESET,
	parameter logic [1:0]  MODE_INIT   = hall_phase_pkg::MODE_RESET
) (
	// clock and reset
	input  wire logic                       clock,
	input  wire logic                       rst,
	// register port
	input  wire logic [15:0]                addr,
	input  wire logic [31:0]                wdata,
	input  wire logic                       wr,
	input  wire logic                       rd,
	output logic      [31:0]                rdata_q,
	// sensor pins
	input  wire hall_phase_pkg::hall_pins_s hall_pins,
	input  wire logic                       in_position,
	// motor side
	output logic      [23:0]                phase_position_q,
	output logic                            motor_enable_q,
	output logic                            irq_q
);
	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------
	function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
		return a == off;
	endfunction : hit

	logic [23:0]                  config_q;
	logic [1:0]                   mode_q;
	logic [23:0]                  stored_q;
	logic [8:0]                   angle_set_q;
	logic [23:0]                  cycle_q;
	logic [hall_phase_pkg::IRQ_W-1:0] mask_q;
	logic [hall_phase_pkg::IRQ_W-1:0] stat_q;
	logic [hall_phase_pkg::IRQ_W-1:0] event_d;
	hall_phase_pkg::phase_state_e state_q;
	logic [7:0]                   settle_q;
	logic                         auto_q;
	logic                         phased_q;
	logic [4:0]                   pins_s;
	logic [3:0]                   nibble;
	logic                         in_pos_s;
	logic                         cmd_phase;
	logic                         cmd_corr;
	logic                         corr_ok;
	logic                         load_good;
	logic                         map_valid;
	logic [7:0]                   map_angle;
	logic [39:0]                  product;
	logic [23:0]                  seed_pos;
	logic [31:0]                  rdata_d;
	hall_phase_pkg::map_cfg_s     map_cfg;

	// ------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------
	pin_sync3 #(
		.W(5)
	) u_sync (
		.clock  (clock),
		.rst    (rst),
		.pin_in ({in_position, hall_pins}),
		.pin_out(pins_s)
	);

	assign nibble   = pins_s[3:0];
	assign in_pos_s = pins_s[4];

	// ------------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			config_q    <= CONFIG_INIT;
			mode_q      <= MODE_INIT;
			stored_q    <= 24'h000000;
			angle_set_q <= 9'h000;
			cycle_q     <= hall_phase_pkg::CYCLE_RESET;
			mask_q      <= '0;
		end else if (wr) begin
			if (hit(addr, hall_phase_pkg::OFF_CONFIG))   config_q    <= wdata[23:0];
			if (hit(addr, hall_phase_pkg::OFF_MODE))     mode_q      <= wdata[1:0];
			if (hit(addr, hall_phase_pkg::OFF_STORED))   stored_q    <= wdata[23:0];
			if (hit(addr, hall_phase_pkg::OFF_ANGLE))    angle_set_q <= wdata[8:0];
			if (hit(addr, hall_phase_pkg::OFF_CYCLE))    cycle_q     <= wdata[23:0];
			if (hit(addr, hall_phase_pkg::OFF_IRQ_MASK)) mask_q      <= wdata[3:0];
		end
	end

	assign cmd_phase = wr && hit(addr, hall_phase_pkg::OFF_CONTROL)
		&& wdata[hall_phase_pkg::CTL_PHASE_BIT];
	assign cmd_corr  = wr && hit(addr, hall_phase_pkg::OFF_CONTROL)
		&& wdata[hall_phase_pkg::CTL_CORR_BIT];
	// correction only once the motor reports in position, never mid-phasing
	assign corr_ok   = cmd_corr && in_pos_s && state_q == hall_phase_pkg::ST_IDLE;

	// ------------------------------------------------------------------
	// angle mapping
	// ------------------------------------------------------------------
	assign map_cfg.reverse = config_q[hall_phase_pkg::CFG_DIR_BIT];
	assign map_cfg.offset  = config_q[hall_phase_pkg::CFG_OFF_LSB +: 6];
	// setting of exactly 128 keeps the direct sense
	assign map_cfg.rotate  = angle_set_q[hall_phase_pkg::ANGLE_SINE_BIT]
		&& angle_set_q[7:0] > hall_phase_pkg::SINE_LIMIT;

	hall_angle_map u_map (
		.uvw  ({nibble[2], nibble[1], nibble[0]}),
		.cfg  (map_cfg),
		.valid(map_valid),
		.angle(map_angle)
	);

	// hall bits are taken only from the flag register address; any other address fails
	assign load_good = config_q[hall_phase_pkg::CFG_HALL_BIT]
		&& config_q[15:0] == hall_phase_pkg::OFF_FLAGS
		&& map_valid;

	// stored offset plays no part here, only cycle length and angle
	assign product  = 40'(map_angle) * 40'(cycle_q);
	assign seed_pos = 24'(product / 40'(hall_phase_pkg::STEPS_PER_CYCLE));

	// ------------------------------------------------------------------
	// phasing sequence
	// ------------------------------------------------------------------
	// auto request lives one cycle after reset; inputs settle before sampling
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			auto_q <= 1'b1;
		end else begin
			auto_q <= 1'b0;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			state_q  <= hall_phase_pkg::ST_IDLE;
			settle_q <= 8'h00;
		end else begin
			unique case (state_q)
				hall_phase_pkg::ST_IDLE: begin
					settle_q <= 8'h00;
					if ((auto_q && mode_q == hall_phase_pkg::MODE_AUTO) || cmd_phase) begin
						state_q <= hall_phase_pkg::ST_SETTLE;
					end
				end
				hall_phase_pkg::ST_SETTLE: begin
					settle_q <= settle_q + 8'h01;
					if (settle_q == 8'(hall_phase_pkg::SETTLE_CYCLES - 1)) begin
						state_q <= hall_phase_pkg::ST_LOAD;
					end
				end
				hall_phase_pkg::ST_LOAD: begin
					state_q <= hall_phase_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------------
	// phase position and motor enable
	// ------------------------------------------------------------------
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			phase_position_q <= 24'h000000;
		end else if (state_q == hall_phase_pkg::ST_LOAD) begin
			if (load_good) phase_position_q <= seed_pos;
		end else if (corr_ok) begin
			phase_position_q <= stored_q;
		end else if (wr && hit(addr, hall_phase_pkg::OFF_PHASE)) begin
			phase_position_q <= wdata[23:0];
		end
	end

	// motor stays off while phasing and after a failed attempt
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			motor_enable_q <= 1'b0;
			phased_q       <= 1'b0;
		end else if (state_q == hall_phase_pkg::ST_SETTLE) begin
			motor_enable_q <= 1'b0;
			phased_q       <= 1'b0;
		end else if (state_q == hall_phase_pkg::ST_LOAD) begin
			motor_enable_q <= load_good;
			phased_q       <= load_good;
		end
	end

	// ------------------------------------------------------------------
	// interrupts
	// ------------------------------------------------------------------
	always_comb begin
		event_d = '0;
		event_d[hall_phase_pkg::IRQ_DONE]    = state_q == hall_phase_pkg::ST_LOAD && load_good;
		event_d[hall_phase_pkg::IRQ_FAIL]    = state_q == hall_phase_pkg::ST_LOAD && !load_good;
		event_d[hall_phase_pkg::IRQ_CORR]    = corr_ok;
		event_d[hall_phase_pkg::IRQ_REFUSED] = cmd_corr && !corr_ok;
	end

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			stat_q <= '0;
		end else if (wr && hit(addr, hall_phase_pkg::OFF_IRQ_STAT)) begin
			stat_q <= (stat_q & ~wdata[3:0]) | event_d;
		end else begin
			stat_q <= stat_q | event_d;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_q & mask_q);
		end
	end

	// ------------------------------------------------------------------
	// read port
	// ------------------------------------------------------------------
	always_comb begin
		rdata_d = 32'h00000000;
		unique case (addr)
			hall_phase_pkg::OFF_CONFIG:   rdata_d = {8'h00, config_q};
			hall_phase_pkg::OFF_MODE:     rdata_d = {30'h00000000, mode_q};
			hall_phase_pkg::OFF_STORED:   rdata_d = {8'h00, stored_q};
			hall_phase_pkg::OFF_ANGLE:    rdata_d = {23'h000000, angle_set_q};
			hall_phase_pkg::OFF_CYCLE:    rdata_d = {8'h00, cycle_q};
			hall_phase_pkg::OFF_PHASE:    rdata_d = {8'h00, phase_position_q};
			hall_phase_pkg::OFF_STATUS:   rdata_d = {25'h0000000, in_pos_s, phased_q,
				state_q != hall_phase_pkg::ST_IDLE, nibble};
			hall_phase_pkg::OFF_IRQ_STAT: rdata_d = {28'h0000000, stat_q};
			hall_phase_pkg::OFF_IRQ_MASK: rdata_d = {28'h0000000, mask_q};
			hall_phase_pkg::OFF_FLAGS:    rdata_d = {8'h00, nibble, 20'h00000};
			default:                      rdata_d = 32'h00000000;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rd ? rdata_d : 32'h00000000;
		end
	end

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	property p_hall_select;
		@(posedge clock) disable iff (rst)
		state_q == hall_phase_pkg::ST_LOAD && !config_q[hall_phase_pkg::CFG_HALL_BIT]
		|=> stat_q[hall_phase_pkg::IRQ_FAIL] && !motor_enable_q;
	endproperty
	a_hall_select: assert property (p_hall_select) else $error("non-hall config not failed");

	property p_flag_addr;
		@(posedge clock) disable iff (rst)
		state_q == hall_phase_pkg::ST_LOAD && config_q[15:0] != hall_phase_pkg::OFF_FLAGS
		|=> !motor_enable_q && $stable(phase_position_q);
	endproperty
	a_flag_addr: assert property (p_flag_addr) else $error("wrong address still phased");

	property p_invalid_state;
		@(posedge clock) disable iff (rst)
		state_q == hall_phase_pkg::ST_LOAD && (nibble[2:0] == 3'h0 || nibble[2:0] == 3'h7)
		|=> !motor_enable_q && !phased_q && stat_q[hall_phase_pkg::IRQ_FAIL];
	endproperty
	a_invalid_state: assert property (p_invalid_state) else $error("invalid hall state accepted");

	property p_seed_load;
		@(posedge clock) disable iff (rst)
		state_q == hall_phase_pkg::ST_LOAD && load_good
		|=> phase_position_q == $past(seed_pos) && motor_enable_q;
	endproperty
	a_seed_load: assert property (p_seed_load) else $error("seed angle not loaded");

	property p_auto_start;
		@(posedge clock) disable iff (rst)
		// sampled reset keeps the release edge itself out of the antecedent
		!rst && auto_q && mode_q == hall_phase_pkg::MODE_AUTO
		|=> state_q == hall_phase_pkg::ST_SETTLE ##6 state_q == hall_phase_pkg::ST_LOAD;
	endproperty
	a_auto_start: assert property (p_auto_start) else $error("auto phasing missed");

	property p_no_auto;
		@(posedge clock) disable iff (rst)
		state_q == hall_phase_pkg::ST_IDLE && mode_q != hall_phase_pkg::MODE_AUTO && !cmd_phase
		|=> state_q == hall_phase_pkg::ST_IDLE;
	endproperty
	a_no_auto: assert property (p_no_auto) else $error("phasing began without command");

	property p_correction;
		@(posedge clock) disable iff (rst)
		cmd_corr && in_pos_s && state_q == hall_phase_pkg::ST_IDLE
		|=> phase_position_q == $past(stored_q) && stat_q[hall_phase_pkg::IRQ_CORR];
	endproperty
	a_correction: assert property (p_correction) else $error("correction not applied");

	property p_corr_wait;
		@(posedge clock) disable iff (rst)
		cmd_corr && !in_pos_s && state_q == hall_phase_pkg::ST_IDLE
		|=> $stable(phase_position_q) && stat_q[hall_phase_pkg::IRQ_REFUSED];
	endproperty
	a_corr_wait: assert property (p_corr_wait) else $error("correction before in position");

	property p_irq_level;
		@(posedge clock) disable iff (rst)
		(stat_q & mask_q) != '0 ##1 (stat_q & mask_q) != '0 |-> irq_q;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	property p_read_idle;
		@(posedge clock) disable iff (rst)
		!rd |=> rdata_q == 32'h00000000;
	endproperty
	a_read_idle: assert property (p_read_idle) else $error("read data outside read cycle");

	// load and correction outrank a direct write, so only plain cycles are checked
	property p_phase_write;
		@(posedge clock) disable iff (rst)
		wr && addr == hall_phase_pkg::OFF_PHASE && state_q != hall_phase_pkg::ST_LOAD
		|=> phase_position_q == 24'($past(wdata));
	endproperty
	a_phase_write: assert property (p_phase_write) else $error("direct position write lost");
endmodule : hall_phase_reference

/* rtl/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync3 #(
	parameter int W = 5
) (
	// clock and reset
	input  wire logic         clock,
	input  wire logic         rst,
	// pins and filtered result
	input  wire logic [W-1:0] pin_in,
	output logic      [W-1:0] pin_out
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	// first stage feeds only the second
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	assign agree = ~(s2_q ^ s3_q);

	// a bit moves only once stages two and three agree
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			pin_out <= '0;
		end else begin
			pin_out <= (s3_q & agree) | (pin_out & ~agree);
		end
	end
endmodule : pin_sync3

/* test/hall_sensor_model.sv */
// hall sensor model: three 50% duty sensors spaced 120 electrical degrees
`timescale 1ns/10ps
module hall_sensor_model (
	// rotor angle in 1/192 cycle, fault select (1 all low, 2 all high), t flag
	input  wire logic [7:0]            angle,
	input  wire logic [1:0]            fault,
	input  wire logic                  t_flag,
	// sensor pins
	output hall_phase_pkg::hall_pins_s pins
);
	// each sensor is high for exactly half of the 192 steps
	function automatic logic high(input logic [7:0] a, input int start);
		return ((int'(a) + 192 - start) % 192) < 96;
	endfunction : high

	// a broken harness reads all low or all high, never a valid zone
	always_comb begin
		pins.t = t_flag;
		pins.u = high(angle, 64);
		pins.v = high(angle, 0);
		pins.w = high(angle, 128);
		if (fault != 2'h0) begin
			pins.u = fault[1];
			pins.v = fault[1];
			pins.w = fault[1];
		end
	end
endmodule : hall_sensor_model

/* test/tb_hall_phase_reference.sv */
// self-checking bench for the hall phase reference block
`timescale 1ns/10ps
module tb_hall_phase_reference;
	logic                       clock, rst, wr, rd, in_position, t_flag, motor_enable_q, irq_q;
	logic [15:0]                addr;
	logic [31:0]                wdata, rdata_q, rv;
	logic [23:0]                phase_position_q, cfg, cyc, stored, expd;
	logic [8:0]                 ang;
	logic [7:0]                 angle;
	logic [1:0]                 fault;
	hall_phase_pkg::hall_pins_s hall_pins;
	integer                     seed, bad_count, total_checks, i;

	hall_phase_reference dut (.clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata_q(rdata_q), .hall_pins(hall_pins), .in_position(in_position),
		.phase_position_q(phase_position_q), .motor_enable_q(motor_enable_q), .irq_q(irq_q));
	hall_sensor_model hall (.angle(angle), .fault(fault), .t_flag(t_flag), .pins(hall_pins));

	always #5 clock = ~clock;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [23:0] exp_pos(input logic [7:0] a, input logic [23:0] c,
		input logic [8:0] g, input logic [23:0] cl);
		int m;
		m = (int'(a) / 32) * 32 + 16;
		if (c[22]) m = (192 - m) % 192;
		m = (m + 3 * int'(c[21:16])) % 192;
		if (g[8] && g[7:0] > 8'h80) m = (m + 96) % 192;
		return 24'((longint'(m) * longint'(cl)) / 192);
	endfunction : exp_pos

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : check

	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : close_out

	task automatic wr_reg(input logic [15:0] a, input logic [31:0] d);
		@(posedge clock);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wr_reg

	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [15:0] a, output logic [31:0] d);
		@(posedge clock);
		rd <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata_q;
	endtask : rd_reg

	task automatic wait_idle;
		int n;
		for (n = 0; n < 20; n++) begin
			rd_reg(hall_phase_pkg::OFF_STATUS, rv);
			if (rv[4] === 1'b0) break;
		end
		if (n == 20) begin
			bad_count++;
			close_out;
		end
	endtask : wait_idle

	task automatic phase;
		wr_reg(hall_phase_pkg::OFF_CONTROL, 32'h1);
		wait_idle;
	endtask : phase

	task automatic settle;
		repeat (2) @(posedge clock);
		#1;
	endtask : settle

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'h5BB45B5B;
		bad_count = 0;
		total_checks = 0;
		clock = 1'b0;
		rst = 1'b1;
		{wr, rd, in_position, t_flag, addr, wdata, fault} = '0;
		angle = 8'h28;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		wait_idle;
		check("auto_pos", {8'h0, exp_pos(8'h28, hall_phase_pkg::CONFIG_RESET, 9'h0,
			hall_phase_pkg::CYCLE_RESET)}, {8'h0, phase_position_q});
		check("auto_en", 32'h1, {31'h0, motor_enable_q});
		rd_reg(hall_phase_pkg::OFF_CONFIG, rv);
		check("config_rst", {8'h0, hall_phase_pkg::CONFIG_RESET}, rv);
		rd_reg(hall_phase_pkg::OFF_MODE, rv);
		check("mode_rst", 32'h1, rv);
		rd_reg(hall_phase_pkg::OFF_CYCLE, rv);
		check("cycle_rst", {8'h0, hall_phase_pkg::CYCLE_RESET}, rv);
		rd_reg(hall_phase_pkg::OFF_STORED, rv);
		check("stored_rst", 32'h0, rv);
		rd_reg(hall_phase_pkg::OFF_IRQ_MASK, rv);
		check("mask_rst", 32'h0, rv);
		rd_reg(hall_phase_pkg::OFF_IRQ_STAT, rv);
		check("auto_done", 32'h1, rv);
		$display("test reset done");
		// random setups, with the offset and angle-setting corners first
		for (i = 0; i < 16; i++) begin
			cfg = {1'b1, 1'($random(seed)), 6'($random(seed)), 16'hC000};
			if (i == 0) cfg[21:16] = 6'h3F;
			ang = 9'($random(seed));
			if (i < 2) ang = {1'b1, 8'h80 + 8'(i)};
			cyc = 24'($random(seed));
			stored = 24'($random(seed));
			t_flag <= 1'($random(seed));
			angle <= 8'($unsigned($random(seed)) % 192);
			wr_reg(hall_phase_pkg::OFF_CONFIG, {8'h0, cfg});
			wr_reg(hall_phase_pkg::OFF_ANGLE, {23'h0, ang});
			wr_reg(hall_phase_pkg::OFF_CYCLE, {8'h0, cyc});
			wr_reg(hall_phase_pkg::OFF_STORED, {8'h0, stored});
			repeat (6) @(posedge clock);
			phase;
			check("phase_pos", {8'h0, exp_pos(angle, cfg, ang, cyc)},
				{8'h0, phase_position_q});
			check("phase_en", 32'h1, {31'h0, motor_enable_q});
			rd_reg(hall_phase_pkg::OFF_FLAGS, rv);
			check("flag_bits", {28'h0, hall_pins}, {28'h0, rv[23:20]});
			rd_reg(hall_phase_pkg::OFF_STATUS, rv);
			check("nibble", {28'h0, hall_pins}, {28'h0, rv[3:0]});
		end
		$display("test random phasing done");
		// all-low and all-high sensors, sensor type off, wrong source address
		for (i = 0; i < 4; i++) begin
			expd = phase_position_q;
			fault <= (i < 2) ? 2'(i + 1) : 2'h0;
			cfg = (i == 2) ? 24'h00C000 : ((i == 3) ? 24'h80C004 : 24'h80C000);
			wr_reg(hall_phase_pkg::OFF_CONFIG, {8'h0, cfg});
			wr_reg(hall_phase_pkg::OFF_IRQ_STAT, 32'hF);
			repeat (6) @(posedge clock);
			phase;
			check("fail_en", 32'h0, {31'h0, motor_enable_q});
			check("fail_pos", {8'h0, expd}, {8'h0, phase_position_q});
			rd_reg(hall_phase_pkg::OFF_IRQ_STAT, rv);
			check("fail_irq", 32'h2, rv);
		end
		fault <= 2'h0;
		$display("test failures done");
		// interrupt raised, masked and cleared
		wr_reg(hall_phase_pkg::OFF_CONFIG, 32'h0080C000);
		wr_reg(hall_phase_pkg::OFF_IRQ_STAT, 32'hF);
		wr_reg(hall_phase_pkg::OFF_IRQ_MASK, 32'h1);
		repeat (6) @(posedge clock);
		phase;
		check("irq_on", 32'h1, {31'h0, irq_q});
		wr_reg(hall_phase_pkg::OFF_IRQ_MASK, 32'h2);
		settle;
		check("irq_masked", 32'h0, {31'h0, irq_q});
		wr_reg(hall_phase_pkg::OFF_IRQ_MASK, 32'h1);
		settle;
		check("irq_again", 32'h1, {31'h0, irq_q});
		wr_reg(hall_phase_pkg::OFF_IRQ_STAT, 32'h1);
		settle;
		check("irq_clear", 32'h0, {31'h0, irq_q});
		$display("test interrupt done");
		// home correction refused until in position, then loads stored value
		stored = 24'h5A5A5A;
		expd = phase_position_q;
		wr_reg(hall_phase_pkg::OFF_STORED, {8'h0, stored});
		wr_reg(hall_phase_pkg::OFF_CONTROL, 32'h2);
		#1 check("corr_hold", {8'h0, expd}, {8'h0, phase_position_q});
		rd_reg(hall_phase_pkg::OFF_IRQ_STAT, rv);
		check("corr_refused", 32'h8, rv);
		in_position <= 1'b1;
		repeat (6) @(posedge clock);
		wr_reg(hall_phase_pkg::OFF_CONTROL, 32'h2);
		#1 check("corr_pos", {8'h0, stored}, {8'h0, phase_position_q});
		rd_reg(hall_phase_pkg::OFF_IRQ_STAT, rv);
		check("corr_done", 32'hC, rv);
		// unmapped place reads zero and ignores writes
		wr_reg(16'h0040, 32'hFFFFFFFF);
		rd_reg(16'h0040, rv);
		check("unmapped", 32'h0, rv);
		$display("test correction done");
		// command-only mode, direct position write, then a reset in mid-run
		wr_reg(hall_phase_pkg::OFF_MODE, 32'h0);
		rd_reg(hall_phase_pkg::OFF_MODE, rv);
		check("mode_cmd", 32'h0, rv);
		repeat (10) @(posedge clock);
		rd_reg(hall_phase_pkg::OFF_STATUS, rv);
		check("no_auto", 32'h0, {31'h0, rv[4]});
		wr_reg(hall_phase_pkg::OFF_PHASE, 32'h00123456);
		rd_reg(hall_phase_pkg::OFF_PHASE, rv);
		check("pos_write", 32'h00123456, rv);
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		#1 check("rst_pos", 32'h0, {8'h0, phase_position_q});
		check("rst_en", 32'h0, {31'h0, motor_enable_q});
		@(posedge clock);
		rst <= 1'b0;
		wait_idle;
		check("reauto_pos", {8'h0, exp_pos(angle, hall_phase_pkg::CONFIG_RESET, 9'h0,
			hall_phase_pkg::CYCLE_RESET)}, {8'h0, phase_position_q});
		check("reauto_en", 32'h1, {31'h0, motor_enable_q});
		$display("test mode and reset done");
		close_out;
	end
endmodule : tb_hall_phase_reference
